//--- logic/shadow_port_defs.svh
`ifndef SHADOW_PORT_DEFS_SVH
`define SHADOW_PORT_DEFS_SVH
`define SHADOW_BASE_ADDR 32'h5000_1030
`define SHADOW_WIN_WORDS 16
`define SHADOW_PORT11_ADDR 32'h5000_105C
`define IRQ_STATUS_ADDR 32'h5000_1100
`define IRQ_ENABLE_ADDR 32'h5000_1104
`define IRQ_CLEAR_ADDR 32'h5000_1108
`define LINE_STATUS_ADDR 32'h5000_110C
`define IRQ_RX_OVERRUN_BIT 0
`define IRQ_TX_DROP_BIT 1
`define IRQ_RX_AVAIL_BIT 2
`define IRQ_BITS 3
`define LSR_DR_BIT 0
`define LSR_OE_BIT 1
`define LSR_TX_HOLD_EMPTY_FLAG_BIT 5
`define FIFO_DEPTH_DEFAULT 16
`define DATA_RESET 16'h0000
`endif

//--- logic/shadow_port_pkg.sv
package shadow_port_pkg;
    typedef logic [7:0] char_t;
    typedef enum logic [1:0] {
        ACC_NONE = 2'h0,
        ACC_SHADOW = 2'h1,
        ACC_CTRL = 2'h3
    } acc_kind_t;
endpackage

//--- logic/uart_shadow_data_port.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "shadow_port_defs.svh"
module uart_shadow_data_port #(
    parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic fifo_en_i,
    input wire logic ir_mode_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    input wire logic tx_take_i,
    output logic tx_valid_o,
    output logic [7:0] tx_char_o,
    output logic tx_ir_sel_o,
    output logic rx_data_ready_flag_o,
    output logic overrun_o,
    output logic tx_hold_empty_flag_o,
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two, at least 2");
    end

    function automatic logic in_window(input logic [31:0] a);
        logic [31:0] off;
        off = a - `SHADOW_BASE_ADDR;
        in_window = (a[1:0] == 2'h0) && (off < 32'(`SHADOW_WIN_WORDS * 4));
    endfunction

    // rx char arrives from framing logic in another domain as a level-qualified pulse
    logic rx_v_s1, rx_v_s2, rx_v_s3;
    logic [7:0] rx_c_s1, rx_c_s2;
    always_ff @(posedge clk_sys_i) begin
        rx_v_s1 <= srst_i ? 1'b0 : rx_valid_i;
        rx_v_s2 <= srst_i ? 1'b0 : rx_v_s1;
        rx_v_s3 <= srst_i ? 1'b0 : rx_v_s2;
        rx_c_s1 <= rx_char_i;
        rx_c_s2 <= rx_c_s1;
    end
    wire logic rx_new = rx_v_s2 & ~rx_v_s3;

    shadow_port_pkg::char_t rx_mem [DEPTH];
    shadow_port_pkg::char_t tx_mem [DEPTH];
    logic [AW:0] rx_wp, rx_rp, tx_wp, tx_rp;
    logic [AW:0] next_rx_wp, next_rx_rp, next_tx_wp, next_tx_rp;
    logic [31:0] next_rdata;
    logic [`IRQ_BITS-1:0] irq_status, irq_enable, next_irq_status, next_irq_enable;
    logic overrun, next_overrun;
    logic rx_wr_en, tx_wr_en;
    logic [AW-1:0] rx_wa, tx_wa;
    logic tx_valid, next_tx_valid;
    shadow_port_pkg::char_t tx_char, next_tx_char;

    wire logic [AW:0] rx_cnt = rx_wp - rx_rp;
    wire logic [AW:0] tx_cnt = tx_wp - tx_rp;
    wire logic rx_full = fifo_en_i ? (rx_cnt == (AW+1)'(DEPTH)) : (rx_cnt != '0);
    wire logic tx_full = (tx_cnt == (AW+1)'(DEPTH));
    wire logic rx_dr = (rx_cnt != '0);
    wire logic tx_hold_empty_flag = (tx_cnt == '0);
    wire shadow_port_pkg::acc_kind_t kind = in_window(addr_i) ? shadow_port_pkg::ACC_SHADOW :
        shadow_port_pkg::ACC_CTRL;
    wire logic sh_rd = rd_i && kind == shadow_port_pkg::ACC_SHADOW;
    wire logic sh_wr = wr_i && kind == shadow_port_pkg::ACC_SHADOW;

    always_comb begin
        next_rx_wp = rx_wp;
        next_rx_rp = rx_rp;
        next_tx_wp = tx_wp;
        next_tx_rp = tx_rp;
        next_overrun = overrun;
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        next_rdata = 32'h0000_0000;
        rx_wr_en = 1'b0;
        tx_wr_en = 1'b0;
        rx_wa = rx_wp[AW-1:0];
        tx_wa = tx_wp[AW-1:0];
        if (rd_i && addr_i == `LINE_STATUS_ADDR) begin
            next_overrun = 1'b0;
        end
        if (wr_i && addr_i == `IRQ_CLEAR_ADDR) begin
            next_irq_status = irq_status & ~wdata_i[`IRQ_BITS-1:0];
        end
        if (wr_i && addr_i == `IRQ_ENABLE_ADDR) begin
            next_irq_enable = wdata_i[`IRQ_BITS-1:0];
        end
        // read pops before a same-cycle arrival is judged, so full-then-read still accepts
        if (sh_rd) begin
            next_rdata = {24'h00_0000, rx_mem[rx_rp[AW-1:0]]};
            if (rx_dr) begin
                next_rx_rp = rx_rp + (AW+1)'(1);
            end
        end
        if (rx_new) begin
            if (!fifo_en_i && rx_dr && !sh_rd) begin
                rx_wr_en = 1'b1;
                rx_wa = rx_rp[AW-1:0];
                next_overrun = 1'b1;
                next_irq_status[`IRQ_RX_OVERRUN_BIT] = 1'b1;
            end else if (rx_full && !sh_rd) begin
                next_overrun = 1'b1;
                next_irq_status[`IRQ_RX_OVERRUN_BIT] = 1'b1;
            end else begin
                rx_wr_en = 1'b1;
                next_rx_wp = rx_wp + (AW+1)'(1);
                next_irq_status[`IRQ_RX_AVAIL_BIT] = 1'b1;
            end
        end
        if (tx_take_i && tx_valid) begin
            next_tx_rp = tx_rp + (AW+1)'(1);
        end
        if (sh_wr) begin
            if (!fifo_en_i && !tx_hold_empty_flag) begin
                tx_wr_en = 1'b1;
                tx_wa = tx_rp[AW-1:0];
                if (tx_take_i && tx_valid) begin
                    tx_wa = tx_wp[AW-1:0];
                    next_tx_wp = tx_wp + (AW+1)'(1);
                end
            end else if (tx_full && !(tx_take_i && tx_valid)) begin
                next_irq_status[`IRQ_TX_DROP_BIT] = 1'b1;
            end else begin
                tx_wr_en = 1'b1;
                next_tx_wp = tx_wp + (AW+1)'(1);
            end
        end
        if (rd_i && kind == shadow_port_pkg::ACC_CTRL) begin
            unique case (addr_i)
                `IRQ_STATUS_ADDR: next_rdata = {29'h0, irq_status};
                `IRQ_ENABLE_ADDR: next_rdata = {29'h0, irq_enable};
                `LINE_STATUS_ADDR: next_rdata = {26'h0, tx_hold_empty_flag, 3'h0, overrun, rx_dr};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_tx_valid = (next_tx_wp != next_tx_rp);
        next_tx_char = tx_mem[next_tx_rp[AW-1:0]];
        if (tx_wr_en && tx_wa == next_tx_rp[AW-1:0]) begin
            next_tx_char = wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rx_wr_en) begin
            rx_mem[rx_wa] <= rx_c_s2;
        end
        if (tx_wr_en) begin
            tx_mem[tx_wa] <= wdata_i[7:0];
        end
        if (srst_i) begin
            rx_wp <= '0;
            rx_rp <= '0;
            tx_wp <= '0;
            tx_rp <= '0;
            overrun <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
            tx_valid <= 1'b0;
            rx_data_ready_flag_o <= 1'b0;
            tx_hold_empty_flag_o <= 1'b1;
            tx_char <= 8'h00;
            rdata_o <= 32'h0000_0000;
            tx_ir_sel_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            rx_wp <= next_rx_wp;
            rx_rp <= next_rx_rp;
            tx_wp <= next_tx_wp;
            tx_rp <= next_tx_rp;
            overrun <= next_overrun;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            tx_valid <= next_tx_valid;
            // registered copies of the flags so the outputs come straight from flops
            rx_data_ready_flag_o <= (next_rx_wp != next_rx_rp);
            tx_hold_empty_flag_o <= (next_tx_wp == next_tx_rp);
            tx_char <= next_tx_char;
            rdata_o <= next_rdata;
            tx_ir_sel_o <= ir_mode_i;
            irq_o <= |(next_irq_status & next_irq_enable);
        end
    end

    assign tx_valid_o = tx_valid;
    assign tx_char_o = tx_char;
    assign overrun_o = overrun;
endmodule
`default_nettype wire

//--- verification/serial_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_far_model (
    input wire logic clk_sys_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_char_i,
    output var logic rx_valid_o = 1'b0,
    output var logic [7:0] rx_char_o = 8'h00,
    output var logic tx_take_o = 1'b0
);
    logic stall = 1'b0;
    logic [7:0] got [$];
    // char held one clock longer than the synchroniser needs
    task automatic send(input logic [7:0] c);
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b1;
        rx_char_o <= c;
        repeat (4) @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_char_o <= ~c; // idle bus must not look like the old char
        repeat (4) @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        if (!stall && tx_valid_i && !tx_take_o) begin
            tx_take_o <= 1'b1;
            got.push_back(tx_char_i);
        end else begin
            tx_take_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verification/shadow_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module shadow_port_sva (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic fifo_en_i,
    input wire logic ir_mode_i,
    input wire logic rx_valid_i,
    input wire logic tx_take_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_char_o,
    input wire logic tx_ir_sel_o,
    input wire logic rx_data_ready_flag_o,
    input wire logic overrun_o,
    input wire logic tx_hold_empty_flag_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    logic wwin;
    assign wwin = wr_i && addr_i >= 32'h5000_1030 && addr_i <= 32'h5000_106C;
    property p_upper; rdata_o[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_tx_hold_empty_flag; tx_hold_empty_flag_o == !tx_valid_o; endproperty
    a_tx_hold_empty_flag: assert property (p_tx_hold_empty_flag) else $error("empty flag disagrees with pending");
    property p_ir; !$past(srst_i) |-> tx_ir_sel_o == $past(ir_mode_i); endproperty
    a_ir: assert property (p_ir) else $error("infrared select not following mode");
    property p_repl; wwin && !fifo_en_i && !tx_take_i |=> tx_valid_o && tx_char_o == $past(wdata_i[7:0]); endproperty
    a_repl: assert property (p_repl) else $error("pending char not replaced");
    property p_fill; wwin && fifo_en_i && tx_hold_empty_flag_o |=> !tx_hold_empty_flag_o; endproperty
    a_fill: assert property (p_fill) else $error("fifo write not accepted");
    property p_rdy; $rose(rx_valid_i) |-> ##[1:5] rx_data_ready_flag_o; endproperty
    a_rdy: assert property (p_rdy) else $error("data ready not raised");
    property p_ovr; $rose(rx_valid_i) && rx_data_ready_flag_o && !fifo_en_i && !rd_i |-> ##[1:5] overrun_o; endproperty
    a_ovr: assert property (p_ovr) else $error("overwrite without overrun");
    property p_sticky; overrun_o && !(rd_i && addr_i == 32'h5000_110C) |=> overrun_o; endproperty
    a_sticky: assert property (p_sticky) else $error("overrun lost");
endmodule
bind uart_shadow_data_port shadow_port_sva i_sva (.*);
`default_nettype wire

//--- verification/uart_shadow_data_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_data_port_test;
    localparam logic [31:0] PORT = 32'h5000_105C;
    localparam logic [31:0] LINE_STATUS_REG = 32'h5000_110C;
    localparam logic [31:0] STAT = 32'h5000_1100;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic fifo_en_i = 1'b0;
    logic ir_mode_i = 1'b0;
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o;
    logic rx_valid_i, tx_take_i, tx_valid_o, tx_ir_sel_o, rx_data_ready_flag_o, overrun_o, tx_hold_empty_flag_o, irq_o;
    logic [7:0] rx_char_i, tx_char_o;
    int n_mismatch = 0;
    int comparisons = 0;
    uart_shadow_data_port #(.DEPTH(4)) i_dut (.*);
    serial_far_model i_far (.clk_sys_i, .tx_valid_i(tx_valid_o), .tx_char_i(tx_char_o), .rx_valid_o(rx_valid_i),
        .rx_char_o(rx_char_i), .tx_take_o(tx_take_i));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(rdata_o, exp);
    endtask
    task automatic rst(input logic f);
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        fifo_en_i <= f;
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
    endtask
    task automatic s_rx_direct;
        rst(1'b0);
        ir_mode_i <= 1'b1;
        i_far.send(8'h5A);
        rd(PORT, 32'h5A);
        i_far.send(8'h11);
        i_far.send(8'hC3);
        rd(LINE_STATUS_REG, 32'h23);
        rd(PORT, 32'hC3);
        rd(LINE_STATUS_REG, 32'h20);
        acc(1'b1, 32'h5000_1104, 32'h1);
        repeat (2) @(negedge clk_sys_i);
        check(irq_o, 32'h1);
        rd(STAT, 32'h5);
        acc(1'b1, 32'h5000_1108, 32'h7);
        rd(STAT, 32'h0);
        check(irq_o, 32'h0);
        check(tx_ir_sel_o, 32'h1);
    endtask
    task automatic s_rx_fifo;
        rst(1'b1);
        for (int i = 0; i < 5; i++) i_far.send(8'h30 + 8'(i));
        for (int i = 0; i < 4; i++) rd(32'h5000_1030 + 32'(20 * i), 32'h30 + 32'(i));
        rd(LINE_STATUS_REG, 32'h22);
        rd(32'h5000_1200, 32'h0);
    endtask
    // the far side stalls so every write after the first lands while a char is pending
    task automatic s_tx(input logic f);
        rst(f);
        i_far.got.delete();
        i_far.stall = 1'b1;
        rd(LINE_STATUS_REG, 32'h20);
        for (int i = 0; i < 5; i++) acc(1'b1, PORT, 32'hFFFF_FF40 + 32'(i));
        rd(STAT, f ? 32'h2 : 32'h0);
        i_far.stall = 1'b0;
        repeat (30) @(posedge clk_sys_i);
        check(i_far.got.size(), f ? 32'h4 : 32'h1);
        check(i_far.got[0], f ? 32'h40 : 32'h44);
        check(i_far.got[$], f ? 32'h43 : 32'h44);
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        s_rx_direct();
        s_rx_fifo();
        s_tx(1'b0);
        s_tx(1'b1);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
